// ### src/microstep_indexer.sv
// Microstep indexer with fixed-off-time current chopper for two windings
// Function
// - Mode field picks full to 1/256 step
// - Full step drives both windings at 71%
// - Winding A sine, winding B cosine
// - Angle advances in equal subdivisions
// - Reset puts indexer at 45 degrees home
// - Step edge advances once; soft step advances every cycle it is set
// - Direction pin xor invert bit sets direction
// - Bridge polarity follows table value sign
// - Mode change moves to next valid state
// - Trip cuts drive for programmed off time
// - Reference is sine times current scale, the scale alone in direct drive
// - Sense gain selects chop full scale
// - Fast decay reverses, stops near zero
// - Slow decay turns both low sides on
// - Mixed and auto only in indexer mode
// - Mixed decay: fast phase then slow
// - Mixed uses slow when target not falling
// - Auto: trip at end of blanking goes fast
// - Auto fast ends below trip after blanking
// - Auto below trip: on, then slow decay
// - Comparator ignored during blanking after turn-on
// - Threshold change restarts the PWM cycle
// - Direct drive inputs control bridges directly
`timescale 1ns/10ps
module microstep_indexer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic soft_step_bit,
  input wire logic direction_invert_bit,
  input wire logic [3:0] step_mode,
  input wire logic [7:0] current_scale,
  input wire logic [1:0] sense_gain,
  input wire logic [7:0] off_time_field,
  input wire logic [7:0] blanking_interval,
  input wire logic [7:0] fast_phase_duration,
  input wire logic [1:0] decay_select,
  input wire logic direct_drive_select,
  input wire logic [3:0] winding_in,
  input wire logic [1:0] trip_in,
  input wire logic [1:0] zero_in,
  output logic [9:0] position,
  output logic [7:0] dac_a,
  output logic [7:0] dac_b,
  output logic [1:0] sense_gain_sel,
  output logic [3:0] winding_a_output,
  output logic [3:0] winding_b_output
);
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic step_prev;
  logic step_rise;
  logic fwd;
  logic adv;
  logic adv1;
  logic adv2;
  logic [3:0] mode_c;
  logic [9:0] addr_a;
  logic [9:0] addr_b;
  logic [1:0] neg_q;
  logic [1:0] neg_d;
  logic [1:0][7:0] dac;
  logic [1:0][7:0] next_dac;
  logic [1:0] thr_chg;
  logic [1:0] incr;
  logic [1:0] trip_s;
  logic [1:0] zero_s;
  logic [1:0] eff_dec;
  logic [15:0] blank_cyc;
  logic [15:0] off_cyc;
  logic [15:0] fast_cyc;
  stepper_pkg::chop_e st [2];
  logic [15:0] tmr [2];
  logic [15:0] sub [2];
  logic [1:0] hiz;
  logic [3:0] gate [2];
  logic [3:0] next_gate [2];

  sine_rom_if rom_bus();

  sine_rom u_rom (
    .mclk(mclk),
    .port(rom_bus.rom)
  );

  // Folds a position into table address and sign
  function automatic logic [9:0] quad_addr(input logic [9:0] p);
    logic [8:0] k;
    k = p[8] ? stepper_pkg::QUARTER_K - {1'b0, p[7:0]} : {1'b0, p[7:0]};
    quad_addr = {p[9] & (k != 9'h000), k};
  endfunction

  // Next state valid for the resolution, in the given direction
  function automatic logic [9:0] next_pos(input logic [9:0] p, input logic [3:0] m, input logic f);
    logic [9:0] inc;
    logic [9:0] off;
    logic [9:0] q;
    logic [9:0] al;
    inc = 10'h001 << (stepper_pkg::MODE_MAX - m);
    off = (m == 4'h0) ? stepper_pkg::HOME_POS : 10'h000;
    q = p - off;
    al = q & ~(inc - 10'h001);
    if (f) next_pos = al + inc + off;
    else if (al == q) next_pos = al - inc + off;
    else next_pos = al + off;
  endfunction

  // Pins pass two flip-flops before use
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1 <= 10'h000;
      sync2 <= 10'h000;
      step_prev <= 1'b0;
    end else begin
      sync1 <= {zero_in, trip_in, winding_in, dir_pin, step_pin};
      sync2 <= sync1;
      step_prev <= sync2[0];
    end
  end

  assign step_rise = sync2[0] & ~step_prev;
  assign fwd = sync2[1] ^ direction_invert_bit;
  assign adv = step_rise | soft_step_bit;
  assign mode_c = (step_mode > stepper_pkg::MODE_MAX) ? stepper_pkg::MODE_MAX : step_mode;
  assign trip_s = sync2[7:6];
  assign zero_s = sync2[9:8];

  // Indexer position, 1024 microsteps per electrical turn
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      position <= stepper_pkg::HOME_POS;
    end else if (adv) begin
      position <= next_pos(position, mode_c, fwd);
    end
  end

  always_comb begin
    addr_a = quad_addr(position);
    addr_b = quad_addr(position + stepper_pkg::QUARTER_POS);
  end

  assign rom_bus.addr[0] = addr_a[8:0];
  assign rom_bus.addr[1] = addr_b[8:0];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_dac[i] = direct_drive_select ? current_scale
        : 8'(({8'h00, rom_bus.mag[i]} * {8'h00, current_scale}) >> 8);
    end
  end

  // Reference codes, sign and trend per winding
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adv1 <= 1'b0;
      adv2 <= 1'b0;
      neg_q <= 2'b00;
      neg_d <= 2'b00;
      dac <= '0;
      thr_chg <= 2'b00;
      incr <= 2'b11;
      sense_gain_sel <= 2'b00;
    end else begin
      adv1 <= adv;
      adv2 <= adv1;
      neg_q <= {addr_b[9], addr_a[9]};
      neg_d <= neg_q;
      dac <= next_dac;
      sense_gain_sel <= sense_gain;
      for (int i = 0; i < 2; i++) begin
        thr_chg[i] <= next_dac[i] != dac[i];
        if (adv2) incr[i] <= next_dac[i] >= dac[i];
      end
    end
  end

  assign dac_a = dac[0];
  assign dac_b = dac[1];

  always_comb begin
    blank_cyc = stepper_pkg::ns_to_cycles(stepper_pkg::BLANK_BASE_NS
      + int'(blanking_interval) * stepper_pkg::BLANK_STEP_NS);
    off_cyc = stepper_pkg::ns_to_cycles((int'(off_time_field) + 1) * stepper_pkg::OFF_STEP_NS);
    fast_cyc = stepper_pkg::ns_to_cycles(int'(fast_phase_duration) * stepper_pkg::FAST_STEP_NS);
    eff_dec = (direct_drive_select && decay_select[1]) ? stepper_pkg::DEC_SLOW : decay_select;
  end

  for (genvar w = 0; w < 2; w++) begin : g_chop
    // PWM cycle state per winding
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        st[w] <= stepper_pkg::CH_ON;
        tmr[w] <= 16'h0000;
        sub[w] <= 16'h0000;
        hiz[w] <= 1'b0;
      end else if (thr_chg[w]) begin
        st[w] <= stepper_pkg::CH_ON;
        tmr[w] <= 16'h0000;
        hiz[w] <= 1'b0;
      end else begin
        case (st[w])
          stepper_pkg::CH_ON: begin
            if (tmr[w] != stepper_pkg::TMR_MAX) tmr[w] <= tmr[w] + 16'h0001;
            if (tmr[w] >= blank_cyc && trip_s[w]) begin
              tmr[w] <= 16'h0000;
              sub[w] <= 16'h0000;
              hiz[w] <= 1'b0;
              if (eff_dec == stepper_pkg::DEC_AUTO) begin
                st[w] <= (tmr[w] == blank_cyc) ? stepper_pkg::CH_FAST : stepper_pkg::CH_SLOW;
              end else if (eff_dec == stepper_pkg::DEC_FAST
                           || (eff_dec == stepper_pkg::DEC_MIXED && !incr[w])) begin
                st[w] <= stepper_pkg::CH_FAST;
              end else begin
                st[w] <= stepper_pkg::CH_SLOW;
              end
            end
          end
          stepper_pkg::CH_FAST: begin
            tmr[w] <= tmr[w] + 16'h0001;
            if (sub[w] != stepper_pkg::TMR_MAX) sub[w] <= sub[w] + 16'h0001;
            if (zero_s[w]) hiz[w] <= 1'b1;
            if (tmr[w] >= off_cyc - 16'h0001) begin
              st[w] <= stepper_pkg::CH_ON;
              tmr[w] <= 16'h0000;
              hiz[w] <= 1'b0;
            end else if (eff_dec == stepper_pkg::DEC_MIXED && sub[w] >= fast_cyc - 16'h0001) begin
              st[w] <= stepper_pkg::CH_SLOW;
            end else if (eff_dec == stepper_pkg::DEC_AUTO && sub[w] >= blank_cyc - 16'h0001 && !trip_s[w]) begin
              st[w] <= stepper_pkg::CH_SLOW;
            end
          end
          stepper_pkg::CH_SLOW: begin
            tmr[w] <= tmr[w] + 16'h0001;
            if (tmr[w] >= off_cyc - 16'h0001) begin
              st[w] <= stepper_pkg::CH_ON;
              tmr[w] <= 16'h0000;
            end
          end
          default: begin
            st[w] <= stepper_pkg::CH_ON;
            tmr[w] <= 16'h0000;
          end
        endcase
      end
    end

    // Bridge gate pattern from cycle state and polarity
    always_comb begin
      logic pos_dir;
      logic in1;
      logic in2;
      in1 = sync2[2 + 2 * w];
      in2 = sync2[3 + 2 * w];
      pos_dir = direct_drive_select ? in1 : ~neg_d[w];
      case (st[w])
        stepper_pkg::CH_ON: next_gate[w] = pos_dir ? stepper_pkg::GATE_FWD : stepper_pkg::GATE_REV;
        stepper_pkg::CH_FAST: next_gate[w] = hiz[w] ? stepper_pkg::GATE_OFF
          : (pos_dir ? stepper_pkg::GATE_REV : stepper_pkg::GATE_FWD);
        stepper_pkg::CH_SLOW: next_gate[w] = stepper_pkg::GATE_SLOW;
        default: next_gate[w] = stepper_pkg::GATE_OFF;
      endcase
      if (direct_drive_select && in1 == in2) begin
        next_gate[w] = in1 ? stepper_pkg::GATE_SLOW : stepper_pkg::GATE_OFF;
      end
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) gate[w] <= stepper_pkg::GATE_OFF;
      else gate[w] <= next_gate[w];
    end
  end

  assign winding_a_output = gate[0];
  assign winding_b_output = gate[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_zero_scale;
    (current_scale == 8'h00 && !direct_drive_select) [*3];
  endsequence

  AST_HOME: assert property ($rose(rst_n) |-> position == stepper_pkg::HOME_POS)
    else $error("position not home after reset");
  AST_HOLD: assert property (!adv |=> $stable(position))
    else $error("position moved without a step");
  AST_FULL: assert property (adv && mode_c == 4'h0 |=> position[7:0] == 8'h80)
    else $error("full step left the 45 degree lattice");
  AST_QUARTER: assert property (adv && mode_c == 4'h2 && !fwd |=> position[5:0] == 6'h00
    && position != $past(position))
    else $error("quarter step reverse not aligned");
  AST_EDGE: assert property (step_rise |=> !step_rise)
    else $error("step edge seen twice");
  AST_BLANK: assert property (st[0] == stepper_pkg::CH_ON && tmr[0] < blank_cyc |=> st[0] == stepper_pkg::CH_ON)
    else $error("chop during blanking");
  AST_RESTART: assert property (thr_chg[0] |=> st[0] == stepper_pkg::CH_ON && tmr[0] == 16'h0000)
    else $error("threshold change did not restart cycle");
  AST_OFF: assert property (st[0] != stepper_pkg::CH_ON && !thr_chg[0] && tmr[0] < off_cyc - 16'h0001
    |=> st[0] != stepper_pkg::CH_ON)
    else $error("off time ended early");
  AST_SCALE: assert property (s_zero_scale |-> dac_a == 8'h00 && dac_b == 8'h00)
    else $error("zero scale gave nonzero reference");
endmodule // microstep_indexer

// ### common/stepper_pkg.sv
// Constants, types and shared arithmetic for the microstep indexer and chopper
package stepper_pkg;
  localparam int CLK_NS = 8;
  localparam int OFF_STEP_NS = 500;
  localparam int BLANK_BASE_NS = 1000;
  localparam int BLANK_STEP_NS = 20;
  localparam int FAST_STEP_NS = 500;
  localparam int HALF_TURN = 512;
  localparam int MAG_FULL = 255;
  localparam logic [9:0] HOME_POS = 10'h080;
  localparam logic [9:0] QUARTER_POS = 10'h100;
  localparam logic [8:0] QUARTER_K = 9'h100;
  localparam logic [3:0] MODE_MAX = 4'h8;
  localparam logic [15:0] TMR_MAX = 16'hffff;
  localparam logic [1:0] DEC_SLOW = 2'h0;
  localparam logic [1:0] DEC_FAST = 2'h1;
  localparam logic [1:0] DEC_MIXED = 2'h2;
  localparam logic [1:0] DEC_AUTO = 2'h3;
  // Gate word {high1, low1, high2, low2}
  localparam logic [3:0] GATE_OFF = 4'h0;
  localparam logic [3:0] GATE_FWD = 4'h9;
  localparam logic [3:0] GATE_REV = 4'h6;
  localparam logic [3:0] GATE_SLOW = 4'h5;

  typedef enum logic [1:0] {
    CH_ON = 2'b00,
    CH_FAST = 2'b01,
    CH_SLOW = 2'b10
  } chop_e;

  // Least time in ns to whole cycles, never below one
  function automatic logic [15:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    ns_to_cycles = 16'(c);
  endfunction

  // Sine magnitude for k/256 of a quarter turn, scaled to 255
  function automatic logic [7:0] sine_mag(input int k);
    int p;
    p = k * (HALF_TURN - k);
    sine_mag = 8'(MAG_FULL * 16 * p / (5 * HALF_TURN * HALF_TURN - 4 * p));
  endfunction
endpackage

// ### common/sine_rom_if.sv
// Two read ports between the indexer and the sine table
`timescale 1ns/10ps
interface sine_rom_if;
  logic [1:0][8:0] addr;
  logic [1:0][7:0] mag;
  modport host (output addr, input mag);
  modport rom (input addr, output mag);
endinterface // sine_rom_if

// ### src/sine_rom.sv
// Quarter-wave sine table with registered read data
`timescale 1ns/10ps
module sine_rom (
  input wire logic mclk,
  sine_rom_if.rom port
);
  logic [7:0] tbl [0:256];

  for (genvar g = 0; g <= 256; g++) begin : g_tbl
    assign tbl[g] = stepper_pkg::sine_mag(g);
  end

  always_ff @(posedge mclk) begin
    port.mag[0] <= tbl[port.addr[0]];
    port.mag[1] <= tbl[port.addr[1]];
  end
endmodule // sine_rom

// ### verification/bridge_model.sv
// Behavioural H-bridge windings with current comparators
`timescale 1ns/10ps
module bridge_model (
  input wire logic mclk,
  input wire logic [3:0] gate_a,
  input wire logic [3:0] gate_b,
  input wire logic [7:0] ref_a,
  input wire logic [7:0] ref_b,
  output logic [1:0] trip,
  output logic [1:0] zero
);
  int cur [2] = '{0, 0};
  always @(posedge mclk) begin
    for (int w = 0; w < 2; w++) begin
      if ((w ? gate_b : gate_a) == stepper_pkg::GATE_FWD) begin
        cur[w] <= cur[w] + 2;
      end else if ((w ? gate_b : gate_a) == stepper_pkg::GATE_REV) begin
        cur[w] <= cur[w] - 2;
      end else if (cur[w] != 0) begin
        cur[w] <= cur[w] - ((cur[w] > 0) ? 1 : -1);
      end
    end
  end
  always_comb begin
    for (int w = 0; w < 2; w++) begin
      trip[w] = ((cur[w] < 0) ? -cur[w] : cur[w]) >= int'(w ? ref_b : ref_a);
      zero[w] = (cur[w] < 3) && (cur[w] > -3);
    end
  end
endmodule // bridge_model

// ### verification/test_microstep_indexer.sv
// Self-checking bench for the microstep indexer and chopper
`timescale 1ns/10ps
module test_microstep_indexer;
  logic mclk = 0, rst_n = 0, step_pin = 0, dir_pin = 1, soft_step_bit = 0, direction_invert_bit = 0;
  logic direct_drive_select = 0;
  logic [3:0] step_mode = 4'h0, winding_in = 4'h0, winding_a_output, winding_b_output;
  logic [7:0] current_scale = 8'hff, off_time_field = 8'h00, blanking_interval = 8'h00;
  logic [7:0] fast_phase_duration = 8'h00, dac_a, dac_b;
  logic [1:0] sense_gain = 2'h0, decay_select = 2'h0, trip_in, zero_in, sense_gain_sel;
  logic [9:0] position;
  int mismatches = 0, total_checks = 0, cycles = 0;

  microstep_indexer u_microstep_indexer (.mclk, .rst_n, .step_pin, .dir_pin, .soft_step_bit,
    .direction_invert_bit, .step_mode, .current_scale, .sense_gain, .off_time_field, .blanking_interval,
    .fast_phase_duration, .decay_select, .direct_drive_select, .winding_in, .trip_in, .zero_in, .position,
    .dac_a, .dac_b, .sense_gain_sel, .winding_a_output, .winding_b_output);
  bridge_model u_bridge_model (.mclk, .gate_a(winding_a_output), .gate_b(winding_b_output),
    .ref_a(dac_a), .ref_b(dac_b), .trip(trip_in), .zero(zero_in));

  initial forever #4 mclk = ~mclk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic soft_step();
    soft_step_bit = 1;
    @(negedge mclk) soft_step_bit = 0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic chop(output int on_len, output int off_len, output logic [3:0] first);
    on_len = 0;
    off_len = 0;
    while (winding_a_output === stepper_pkg::GATE_FWD) @(negedge mclk);
    while (winding_a_output !== stepper_pkg::GATE_FWD) @(negedge mclk);
    while (winding_a_output === stepper_pkg::GATE_FWD) begin
      on_len++;
      @(negedge mclk);
    end
    first = winding_a_output;
    while (winding_a_output !== stepper_pkg::GATE_FWD) begin
      off_len++;
      @(negedge mclk);
    end
  endtask

  task automatic t_reset();
    chk("position", stepper_pkg::HOME_POS, position);
    chk("dac a", 10'h0b3, 10'(dac_a));
    chk("dac b", 10'h0b3, 10'(dac_b));
    sense_gain = 2'h3;
    repeat (2) @(negedge mclk);
    chk("gain", 10'h003, 10'(sense_gain_sel));
  endtask

  task automatic t_decay();
    int on_len, off_len;
    logic [3:0] first;
    logic [3:0] exp_w [4] = '{stepper_pkg::GATE_SLOW, stepper_pkg::GATE_REV, stepper_pkg::GATE_SLOW,
      stepper_pkg::GATE_REV};
    for (int d = 0; d < 4; d++) begin
      decay_select = 2'(d);
      chop(on_len, off_len, first);
      chop(on_len, off_len, first);
      chk("off time", 10'h03f, 10'(off_len));
      chk("min on", 10'h001, 10'(on_len >= 125));
      chk("decay word", 10'(exp_w[d]), 10'(first));
    end
  endtask

  task automatic t_mixed();
    int on_len, off_len, fast_len;
    logic [3:0] first;
    decay_select = 2'h2;
    off_time_field = 8'h01;
    fast_phase_duration = 8'h01;
    step_mode = 4'h2;
    dir_pin = 0;
    repeat (3) @(negedge mclk);
    soft_step();
    chk("position", 10'h040, position);
    chop(on_len, off_len, first);
    chop(on_len, off_len, first);
    chk("off time", 10'h07d, 10'(off_len));
    chk("decay word", 10'(stepper_pkg::GATE_REV), 10'(first));
    fast_len = 0;
    while (winding_a_output === stepper_pkg::GATE_FWD) @(negedge mclk);
    while (winding_a_output === stepper_pkg::GATE_REV) begin
      fast_len++;
      @(negedge mclk);
    end
    chk("fast phase", 10'h03f, 10'(fast_len));
    chk("slow phase", 10'(stepper_pkg::GATE_SLOW), 10'(winding_a_output));
    dir_pin = 1;
    off_time_field = 8'h00;
    fast_phase_duration = 8'h00;
    repeat (3) @(negedge mclk);
    soft_step();
    step_mode = 4'h0;
    chk("position", stepper_pkg::HOME_POS, position);
  endtask

  task automatic t_rerun();
    rst_n = 0;
    repeat (3) @(negedge mclk);
    chk("gate a in reset", 10'(stepper_pkg::GATE_OFF), 10'(winding_a_output));
    rst_n = 1;
    @(negedge mclk);
    chk("position", stepper_pkg::HOME_POS, position);
  endtask

  task automatic t_direct();
    logic [3:0] wi [3] = '{4'h9, 4'hf, 4'h0};
    logic [3:0] ea [3] = '{stepper_pkg::GATE_FWD, stepper_pkg::GATE_SLOW, stepper_pkg::GATE_OFF};
    logic [3:0] eb [3] = '{stepper_pkg::GATE_REV, stepper_pkg::GATE_SLOW, stepper_pkg::GATE_OFF};
    direct_drive_select = 1;
    for (int i = 0; i < 3; i++) begin
      winding_in = wi[i];
      repeat (5) @(negedge mclk);
      chk("bridge a", 10'(ea[i]), 10'(winding_a_output));
      chk("bridge b", 10'(eb[i]), 10'(winding_b_output));
    end
    direct_drive_select = 0;
  endtask

  task automatic t_steps();
    logic [1:0] dv [4] = '{2'b11, 2'b11, 2'b01, 2'b00};
    logic [9:0] ev [4] = '{10'h000, 10'h380, 10'h000, 10'h380};
    for (int i = 1; i < 5; i++) begin
      soft_step();
      chk("position", 10'(128 + i * 256), position);
      chk("dac a", 10'h0b3, 10'(dac_a));
      chk("dac b", 10'h0b3, 10'(dac_b));
    end
    step_mode = 4'h1;
    for (int i = 0; i < 4; i++) begin
      {dir_pin, direction_invert_bit} = dv[i];
      repeat (3) @(negedge mclk);
      soft_step();
      chk("position", ev[i], position);
    end
    step_mode = 4'h8;
    {dir_pin, direction_invert_bit} = 2'b10;
    repeat (3) @(negedge mclk);
    step_pin = 1;
    repeat (8) @(negedge mclk);
    step_pin = 0;
    repeat (8) @(negedge mclk);
    chk("position", 10'h381, position);
    step_mode = 4'h2;
    repeat (3) @(negedge mclk);
    soft_step();
    chk("position", 10'h3c0, position);
    repeat (5) soft_step();
    chk("position", 10'h100, position);
    chk("dac b", 10'h000, 10'(dac_b));
    chk("dac a", 10'h0fe, 10'(dac_a));
    current_scale = 8'h00;
    repeat (4) @(negedge mclk);
    chk("dac a", 10'h000, 10'(dac_a));
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1;
    repeat (3) @(negedge mclk);
    t_reset();
    t_decay();
    t_mixed();
    t_direct();
    t_steps();
    t_rerun();
    summarize();
  end
endmodule // test_microstep_indexer
